//--- iaf_pkg.sv
// Package with register map, flag positions, opcodes and bus structs of the arithmetic flag unit.
`default_nettype none
package iaf_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ACC = 8'h04;
  localparam logic [ADDR_W-1:0] REG_EXT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_SRC = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_DST = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IMM = 8'h14;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h1C;

  // Bit positions inside the flag word.
  localparam int CARRY_BIT = 0;
  localparam int PARITY_BIT = 2;
  localparam int HALF_BIT = 4;
  localparam int ZERO_BIT = 6;
  localparam int SIGN_BIT = 7;
  localparam int TRAP_BIT = 8;
  localparam int IF_BIT = 9;
  localparam int DIR_BIT = 10;
  localparam int OVF_BIT = 11;

  // Only defined flag bits are writable; the rest read as zero.
  localparam logic [15:0] FLAG_RW_MASK = 16'h0FD5;

  // Status register bit positions.
  localparam int STAT_DIV_ERR = 0;
  localparam int STAT_STEP = 1;
  localparam int STAT_BUSY = 2;

  // Bus answer codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Arithmetic operations selectable through the command register.
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_ADC = 4'h1, OP_INC = 4'h2, OP_SUB = 4'h3, OP_SUBB = 4'h4, OP_MINUS1 = 4'h5,
    OP_UPROD = 4'h6, OP_SPROD = 4'h7, OP_SPROD_IMM = 4'h8, OP_UQUOT = 4'h9, OP_SQUOT = 4'hA
  } iaf_op_t;

  // Execution states; idle and run differ in one bit.
  typedef enum logic [0:0] {EX_IDLE = 1'b0, EX_RUN = 1'b1} iaf_exec_t;

  // Command word: bit 5 byte immediate, bit 4 word size, bits 3..0 operation.
  localparam int CMD_W = 6;
  typedef struct packed {
    logic imm_byte;
    logic word;
    iaf_op_t op;
  } iaf_cmd_t;

  // Adder result with its carry, half-carry and overflow indications.
  typedef struct packed {
    logic ovf;
    logic half;
    logic carry;
    logic [15:0] res;
  } iaf_alu_t;

  // AXI4-Lite master to slave signals.
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } iaf_axi_req_t;

  // AXI4-Lite slave to master signals.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } iaf_axi_rsp_t;

endpackage
`default_nettype wire

//--- iaf_unit.sv
// Integer arithmetic datapath with its flag word, reached over AXI4-Lite.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`default_nettype none
module iaf_unit
  import iaf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire iaf_pkg::iaf_axi_req_t axi_req,
  output iaf_pkg::iaf_axi_rsp_t axi_rsp,
  input wire logic irq_req,
  output logic irq_grant,
  output logic step_trap_pulse,
  output logic div_err_pulse,
  output logic dir_decrement
);
  import iaf_pkg::*;

  // Whole state of the unit in one packed record.
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    iaf_exec_t exec;
    iaf_cmd_t cmd;
    logic [15:0] flags;
    logic [15:0] acc;
    logic [15:0] ext;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] imm;
    logic [2:0] stat;
    logic irq_grant;
    logic step_pulse;
    logic div_err;
  } iaf_state_t;

  iaf_state_t st_ff;
  iaf_state_t nxt_st;

  // Merges the written low halfword into a 16-bit register by byte lane.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data, input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  // Adds or subtracts with carry in; byte results keep the upper byte of the first operand.
  function automatic iaf_alu_t add_sub(input logic [15:0] a, input logic [15:0] b, input logic cin,
                                       input logic sub, input logic word);
    logic [15:0] bb;
    logic ci;
    logic [16:0] s16;
    logic [8:0] s8;
    logic [4:0] s4;
    bb = sub ? ~b : b;
    ci = sub ? ~cin : cin;
    s16 = {1'b0, a} + {1'b0, bb} + {16'h0000, ci};
    s8 = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, ci};
    s4 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    add_sub.half = s4[4] ^ sub;
    add_sub.carry = (word ? s16[16] : s8[8]) ^ sub;
    if (word) begin
      add_sub.res = s16[15:0];
      add_sub.ovf = (a[15] == bb[15]) && (s16[15] != a[15]);
    end else begin
      add_sub.res = {a[15:8], s8[7:0]};
      add_sub.ovf = (a[7] == bb[7]) && (s8[7] != a[7]);
    end
  endfunction

  // Updates the status flags from an adder result; carry only when asked.
  function automatic logic [15:0] set_flags(input logic [15:0] f, input iaf_alu_t r, input logic word,
                                            input logic upd_cf);
    set_flags = f;
    set_flags[OVF_BIT] = r.ovf;
    set_flags[HALF_BIT] = r.half;
    set_flags[PARITY_BIT] = ~^r.res[7:0];
    set_flags[SIGN_BIT] = word ? r.res[15] : r.res[7];
    set_flags[ZERO_BIT] = word ? (r.res == 16'h0000) : (r.res[7:0] == 8'h00);
    if (upd_cf) begin
      set_flags[CARRY_BIT] = r.carry;
    end
  endfunction

  logic do_wr;
  logic [15:0] wval;
  iaf_alu_t alu;
  logic [31:0] up32;
  logic [31:0] sp32;
  logic [15:0] imm16;
  logic [15:0] dvs16;
  logic [31:0] dvd32;
  logic [31:0] uq32;
  logic [31:0] ur32;
  logic signed [33:0] sn34;
  logic signed [33:0] sd34;
  logic signed [33:0] sq34;
  logic signed [33:0] sr34;
  logic div_bad;
  logic ovf;

  // Next-state logic: bus slave, register writes and one-cycle execution.
  always_comb begin
    nxt_st = st_ff;
    do_wr = 1'b0;
    wval = 16'h0000;
    alu = '0;
    up32 = 32'h0000_0000;
    sp32 = 32'h0000_0000;
    imm16 = 16'h0000;
    dvs16 = 16'h0000;
    dvd32 = 32'h0000_0000;
    uq32 = 32'h0000_0000;
    ur32 = 32'h0000_0000;
    sn34 = '0;
    sd34 = '0;
    sq34 = '0;
    sr34 = '0;
    div_bad = 1'b0;
    ovf = 1'b0;
    nxt_st.step_pulse = 1'b0;
    nxt_st.div_err = 1'b0;
    nxt_st.irq_grant = irq_req && st_ff.flags[IF_BIT];

    // Write address and data are taken independently and held until both are present.
    if (axi_req.awvalid && st_ff.awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.waddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_ff.wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata = axi_req.wdata;
      nxt_st.wstrb = axi_req.wstrb;
    end
    if (axi_req.bready && st_ff.bvalid) begin
      nxt_st.bvalid = 1'b0;
    end

    // A write waits while an operation runs so software never races the datapath.
    do_wr = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid && (st_ff.exec == EX_IDLE);
    if (do_wr) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      if (st_ff.waddr == REG_FLAGS) begin
        wval = merge16(st_ff.flags, st_ff.wdata, st_ff.wstrb);
        nxt_st.flags = wval & FLAG_RW_MASK;
      end else if (st_ff.waddr == REG_ACC) begin
        nxt_st.acc = merge16(st_ff.acc, st_ff.wdata, st_ff.wstrb);
      end else if (st_ff.waddr == REG_EXT) begin
        nxt_st.ext = merge16(st_ff.ext, st_ff.wdata, st_ff.wstrb);
      end else if (st_ff.waddr == REG_SRC) begin
        nxt_st.src = merge16(st_ff.src, st_ff.wdata, st_ff.wstrb);
      end else if (st_ff.waddr == REG_DST) begin
        nxt_st.dst = merge16(st_ff.dst, st_ff.wdata, st_ff.wstrb);
      end else if (st_ff.waddr == REG_IMM) begin
        nxt_st.imm = merge16(st_ff.imm, st_ff.wdata, st_ff.wstrb);
      end else if (st_ff.waddr == REG_CMD) begin
        if (st_ff.wstrb[0]) begin
          nxt_st.cmd = iaf_cmd_t'(st_ff.wdata[CMD_W-1:0]);
          nxt_st.exec = EX_RUN;
          nxt_st.stat = '0;
          nxt_st.stat[STAT_BUSY] = 1'b1;
        end
      end else if (st_ff.waddr == REG_STAT) begin
        nxt_st.bresp = RESP_OKAY;
      end else begin
        nxt_st.bresp = RESP_SLVERR;
      end
    end
    nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;

    // Read channel: the address is decoded and the data captured on acceptance.
    if (axi_req.rready && st_ff.rvalid) begin
      nxt_st.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = 32'h0000_0000;
      if (axi_req.araddr == REG_FLAGS) begin
        nxt_st.rdata[15:0] = st_ff.flags;
      end else if (axi_req.araddr == REG_ACC) begin
        nxt_st.rdata[15:0] = st_ff.acc;
      end else if (axi_req.araddr == REG_EXT) begin
        nxt_st.rdata[15:0] = st_ff.ext;
      end else if (axi_req.araddr == REG_SRC) begin
        nxt_st.rdata[15:0] = st_ff.src;
      end else if (axi_req.araddr == REG_DST) begin
        nxt_st.rdata[15:0] = st_ff.dst;
      end else if (axi_req.araddr == REG_IMM) begin
        nxt_st.rdata[15:0] = st_ff.imm;
      end else if (axi_req.araddr == REG_CMD) begin
        nxt_st.rdata[CMD_W-1:0] = st_ff.cmd;
      end else if (axi_req.araddr == REG_STAT) begin
        nxt_st.rdata[2:0] = st_ff.stat;
      end
    end
    nxt_st.arready = !nxt_st.rvalid;

    // Operand preparation shared by the multiply and divide forms.
    imm16 = st_ff.cmd.imm_byte ? {{8{st_ff.imm[7]}}, st_ff.imm[7:0]} : st_ff.imm;
    dvs16 = st_ff.cmd.word ? st_ff.src : {8'h00, st_ff.src[7:0]};
    dvd32 = st_ff.cmd.word ? {st_ff.ext, st_ff.acc} : {16'h0000, st_ff.acc};
    if (st_ff.cmd.word) begin
      sn34 = $signed({{2{st_ff.ext[15]}}, st_ff.ext, st_ff.acc});
      sd34 = $signed({{18{st_ff.src[15]}}, st_ff.src});
    end else begin
      sn34 = $signed({{18{st_ff.acc[15]}}, st_ff.acc});
      sd34 = $signed({{26{st_ff.src[7]}}, st_ff.src[7:0]});
    end

    // Execution: every operation completes in the single run cycle.
    if (st_ff.exec == EX_RUN) begin
      nxt_st.exec = EX_IDLE;
      nxt_st.stat[STAT_BUSY] = 1'b0;
      case (st_ff.cmd.op)
        OP_ADD, OP_ADC, OP_INC, OP_SUB, OP_SUBB, OP_MINUS1: begin
          if (st_ff.cmd.op == OP_ADD) begin
            alu = add_sub(st_ff.dst, st_ff.src, 1'b0, 1'b0, st_ff.cmd.word);
          end else if (st_ff.cmd.op == OP_ADC) begin
            alu = add_sub(st_ff.dst, st_ff.src, st_ff.flags[CARRY_BIT], 1'b0, st_ff.cmd.word);
          end else if (st_ff.cmd.op == OP_INC) begin
            alu = add_sub(st_ff.dst, 16'h0001, 1'b0, 1'b0, st_ff.cmd.word);
          end else if (st_ff.cmd.op == OP_SUB) begin
            alu = add_sub(st_ff.dst, st_ff.src, 1'b0, 1'b1, st_ff.cmd.word);
          end else if (st_ff.cmd.op == OP_SUBB) begin
            alu = add_sub(st_ff.dst, st_ff.src, st_ff.flags[CARRY_BIT], 1'b1, st_ff.cmd.word);
          end else begin
            alu = add_sub(st_ff.dst, 16'h0001, 1'b0, 1'b1, st_ff.cmd.word);
          end
          nxt_st.dst = alu.res;
          nxt_st.flags = set_flags(st_ff.flags, alu, st_ff.cmd.word,
                                   (st_ff.cmd.op != OP_INC) && (st_ff.cmd.op != OP_MINUS1));
        end
        OP_UPROD: begin
          if (st_ff.cmd.word) begin
            up32 = {16'h0000, st_ff.acc} * {16'h0000, st_ff.src};
            nxt_st.ext = up32[31:16];
            nxt_st.acc = up32[15:0];
            ovf = (up32[31:16] != 16'h0000);
          end else begin
            up32 = {24'h00_0000, st_ff.acc[7:0]} * {24'h00_0000, st_ff.src[7:0]};
            nxt_st.acc = up32[15:0];
            ovf = (up32[15:8] != 8'h00);
          end
          nxt_st.flags[CARRY_BIT] = ovf;
          nxt_st.flags[OVF_BIT] = ovf;
        end
        OP_SPROD: begin
          if (st_ff.cmd.word) begin
            sp32 = 32'($signed({{16{st_ff.acc[15]}}, st_ff.acc}) * $signed({{16{st_ff.src[15]}}, st_ff.src}));
            nxt_st.ext = sp32[31:16];
            nxt_st.acc = sp32[15:0];
            ovf = (sp32[31:16] != {16{sp32[15]}});
          end else begin
            sp32 = 32'($signed({{24{st_ff.acc[7]}}, st_ff.acc[7:0]}) * $signed({{24{st_ff.src[7]}}, st_ff.src[7:0]}));
            nxt_st.acc = sp32[15:0];
            ovf = (sp32[15:8] != {8{sp32[7]}});
          end
          nxt_st.flags[CARRY_BIT] = ovf;
          nxt_st.flags[OVF_BIT] = ovf;
        end
        OP_SPROD_IMM: begin
          sp32 = 32'($signed({{16{st_ff.src[15]}}, st_ff.src}) * $signed({{16{imm16[15]}}, imm16}));
          nxt_st.dst = sp32[15:0];
          ovf = (sp32[31:16] != {16{sp32[15]}});
          nxt_st.flags[CARRY_BIT] = ovf;
          nxt_st.flags[OVF_BIT] = ovf;
        end
        OP_UQUOT: begin
          if (dvs16 != 16'h0000) begin
            uq32 = dvd32 / {16'h0000, dvs16};
            ur32 = dvd32 % {16'h0000, dvs16};
          end
          div_bad = (dvs16 == 16'h0000) ||
                    (st_ff.cmd.word ? (uq32[31:16] != 16'h0000) : (uq32[15:8] != 8'h00));
          if (!div_bad) begin
            if (st_ff.cmd.word) begin
              nxt_st.acc = uq32[15:0];
              nxt_st.ext = ur32[15:0];
            end else begin
              nxt_st.acc = {ur32[7:0], uq32[7:0]};
            end
          end
        end
        OP_SQUOT: begin
          if (sd34 != 34'sh0_0000_0000) begin
            sq34 = sn34 / sd34;
            sr34 = sn34 % sd34;
          end
          if (st_ff.cmd.word) begin
            div_bad = (sq34 != $signed({{18{sq34[15]}}, sq34[15:0]}));
          end else begin
            div_bad = (sq34 != $signed({{26{sq34[7]}}, sq34[7:0]}));
          end
          div_bad = div_bad || (sd34 == 34'sh0_0000_0000);
          if (!div_bad) begin
            if (st_ff.cmd.word) begin
              nxt_st.acc = sq34[15:0];
              nxt_st.ext = sr34[15:0];
            end else begin
              nxt_st.acc = {sr34[7:0], sq34[7:0]};
            end
          end
        end
        default: begin
          nxt_st.stat[STAT_BUSY] = 1'b0;
        end
      endcase
      if (div_bad) begin
        nxt_st.div_err = 1'b1;
        nxt_st.stat[STAT_DIV_ERR] = 1'b1;
      end
      // Single-step: the trap follows the completed operation and clears its own flag.
      if (st_ff.flags[TRAP_BIT]) begin
        nxt_st.flags[TRAP_BIT] = 1'b0;
        nxt_st.step_pulse = 1'b1;
        nxt_st.stat[STAT_STEP] = 1'b1;
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register, except rresp, which is tied to RESP_OKAY.
  assign axi_rsp.awready = st_ff.awready;
  assign axi_rsp.wready = st_ff.wready;
  assign axi_rsp.bvalid = st_ff.bvalid;
  assign axi_rsp.bresp = st_ff.bresp;
  assign axi_rsp.arready = st_ff.arready;
  assign axi_rsp.rvalid = st_ff.rvalid;
  assign axi_rsp.rdata = st_ff.rdata;
  assign axi_rsp.rresp = RESP_OKAY;
  assign irq_grant = st_ff.irq_grant;
  assign step_trap_pulse = st_ff.step_pulse;
  assign div_err_pulse = st_ff.div_err;
  assign dir_decrement = st_ff.flags[DIR_BIT];

  // Checks on the datapath, flag and bus write behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic run_add;
  assign run_add = (st_ff.exec == EX_RUN) && (st_ff.cmd.op == OP_ADD || st_ff.cmd.op == OP_SUB);

  a_sign_msb: assert property (run_add |=> st_ff.flags[SIGN_BIT] == (st_ff.cmd.word ? st_ff.dst[15] : st_ff.dst[7]))
    else $error("sign flag differs from result msb");
  a_zero_result: assert property (run_add && st_ff.cmd.word |=> st_ff.flags[ZERO_BIT] == (st_ff.dst == 16'h0000))
    else $error("zero flag differs from result");
  a_parity_low: assert property (run_add |=> st_ff.flags[PARITY_BIT] == ~^st_ff.dst[7:0])
    else $error("parity flag wrong");
  a_carry_kept: assert property ((st_ff.exec == EX_RUN) && (st_ff.cmd.op == OP_INC || st_ff.cmd.op == OP_MINUS1)
                                 |=> $stable(st_ff.flags[CARRY_BIT]))
    else $error("increment or decrement changed carry");
  a_step_trap: assert property ((st_ff.exec == EX_RUN) && st_ff.flags[TRAP_BIT]
                                |=> step_trap_pulse && !st_ff.flags[TRAP_BIT] ##1 !step_trap_pulse)
    else $error("single step trap not taken once");
  a_irq_gate: assert property (irq_grant |-> $past(irq_req) && $past(st_ff.flags[IF_BIT]))
    else $error("maskable request passed while disabled");
  a_div_zero: assert property ((st_ff.exec == EX_RUN) && (st_ff.cmd.op == OP_UQUOT) && (st_ff.src == 16'h0000)
                               |=> div_err_pulse && $stable(st_ff.acc) && $stable(st_ff.ext))
    else $error("zero divisor did not raise vector 0");
  a_mul_upper: assert property ((st_ff.exec == EX_RUN) && (st_ff.cmd.op == OP_UPROD) && st_ff.cmd.word
                                |=> st_ff.flags[CARRY_BIT] == (st_ff.ext != 16'h0000) &&
                                    st_ff.flags[OVF_BIT] == st_ff.flags[CARRY_BIT])
    else $error("multiply carry does not match upper half");
  a_resv_zero: assert property ((st_ff.flags & ~FLAG_RW_MASK) == 16'h0000)
    else $error("reserved flag bit set");
  a_write_answer: assert property (do_wr |=> axi_rsp.bvalid && !axi_rsp.awready && !axi_rsp.wready)
    else $error("write not answered");

endmodule
`default_nettype wire

//--- iaf_unit_tb.sv
// Self-checking testbench of the arithmetic flag unit over its register bus.
`default_nettype none
module iaf_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import iaf_pkg::*;

  localparam logic [15:0] zw = 16'h0000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic irq_req = 1'b0;
  iaf_axi_req_t req = '0;
  iaf_axi_rsp_t rsp;
  logic irq_grant, step_trap_pulse, div_err_pulse, dir_decrement;
  logic [7:0] n_div = 8'h00;
  logic [7:0] n_stp = 8'h00;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;

  // Clock of 5 ns period.
  always #2.5 ref_clk = ~ref_clk;

  iaf_unit u_dut (.ref_clk(ref_clk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .irq_req(irq_req),
    .irq_grant(irq_grant), .step_trap_pulse(step_trap_pulse), .div_err_pulse(div_err_pulse),
    .dir_decrement(dir_decrement));

  // Counts event pulses and cuts a hang short.
  always @(posedge ref_clk) begin
    cyc++;
    if (!rst) begin
      n_div <= n_div + {7'h00, div_err_pulse};
      n_stp <= n_stp + {7'h00, step_trap_pulse};
    end
    if (cyc == 10000) begin
      bad_count++;
      conclude();
    end
  end

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write; address and data are each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    chk({30'h0000_0000, rsp.bresp}, {30'h0000_0000, er});
    req.bready <= 1'b0;
  endtask

  // Bus read with comparison of the returned word.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    chk(rsp.rdata, exp);
    chk({30'h0000_0000, rsp.rresp}, {30'h0000_0000, RESP_OKAY});
    req.rready <= 1'b0;
  endtask

  // Loads flags and operands, runs one command, checks registers, flags and status.
  task automatic op(input logic [15:0] f, ac, ex, ds, sr, im, input logic [5:0] c,
                    input logic [15:0] eac, eex, eds, ef, input logic [2:0] es);
    wr(REG_FLAGS, {16'h0000, f}, RESP_OKAY);
    wr(REG_ACC, {16'h0000, ac}, RESP_OKAY);
    wr(REG_EXT, {16'h0000, ex}, RESP_OKAY);
    wr(REG_DST, {16'h0000, ds}, RESP_OKAY);
    wr(REG_SRC, {16'h0000, sr}, RESP_OKAY);
    wr(REG_IMM, {16'h0000, im}, RESP_OKAY);
    wr(REG_CMD, {26'h000_0000, c}, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    rd(REG_ACC, {16'h0000, eac});
    rd(REG_EXT, {16'h0000, eex});
    rd(REG_DST, {16'h0000, eds});
    rd(REG_FLAGS, {16'h0000, ef});
    rd(REG_STAT, {29'h0000_0000, es});
  endtask

  // Main sequence.
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(REG_FLAGS, 32'h0000_0000);
    wr(REG_FLAGS, 32'hFFFF_FFFF, RESP_OKAY);
    rd(REG_FLAGS, 32'h0000_0FD5);
    irq_req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({31'h0000_0000, irq_grant}, 32'h0000_0001);
    chk({31'h0000_0000, dir_decrement}, 32'h0000_0001);
    wr(REG_FLAGS, 32'h0000_0000, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk({31'h0000_0000, irq_grant}, 32'h0000_0000);
    chk({31'h0000_0000, dir_decrement}, 32'h0000_0000);
    irq_req <= 1'b0;
    wr(8'h40, 32'h0000_0001, RESP_SLVERR);
    rd(8'h40, 32'h0000_0000);
    op(zw, zw, zw, 16'h007F, 16'h0001, zw, 6'h00, zw, zw, 16'h0080, 16'h0890, 3'h0);
    op(16'h0001, zw, zw, 16'hFFFF, zw, zw, 6'h11, zw, zw, zw, 16'h0055, 3'h0);
    op(16'h0101, zw, zw, 16'h12FF, zw, zw, 6'h02, zw, zw, 16'h1200, 16'h0055, 3'h2);
    op(zw, zw, zw, zw, 16'h0001, zw, 6'h03, zw, zw, 16'h00FF, 16'h0095, 3'h0);
    op(16'h0001, zw, zw, 16'h8000, zw, zw, 6'h14, zw, zw, 16'h7FFF, 16'h0814, 3'h0);
    op(16'h0001, zw, zw, 16'h0001, zw, zw, 6'h15, zw, zw, zw, 16'h0045, 3'h0);
    op(zw, 16'h0100, zw, zw, 16'h0100, zw, 6'h16, zw, 16'h0001, zw, 16'h0801, 3'h0);
    op(16'h0801, 16'h0010, 16'h5555, zw, 16'h0008, zw, 6'h06, 16'h0080, 16'h5555, zw, zw, 3'h0);
    op(16'h0801, 16'h00FF, zw, zw, 16'h0002, zw, 6'h07, 16'hFFFE, zw, zw, zw, 3'h0);
    op(zw, 16'h0040, zw, zw, 16'h0002, zw, 6'h07, 16'h0080, zw, zw, 16'h0801, 3'h0);
    op(16'h0801, zw, zw, zw, 16'h0100, 16'h00FE, 6'h38, zw, zw, 16'hFE00, zw, 3'h0);
    op(zw, zw, zw, zw, 16'h4000, 16'h0004, 6'h18, zw, zw, zw, 16'h0801, 3'h0);
    op(zw, 16'h0107, zw, zw, 16'h0002, zw, 6'h09, 16'h0183, zw, zw, zw, 3'h0);
    op(zw, 16'h01FE, zw, zw, 16'h0002, zw, 6'h09, 16'h00FF, zw, zw, zw, 3'h0);
    op(zw, 16'h0200, zw, zw, 16'h0002, zw, 6'h09, 16'h0200, zw, zw, zw, 3'h1);
    op(zw, 16'h0005, zw, zw, zw, zw, 6'h19, 16'h0005, zw, zw, zw, 3'h1);
    op(zw, zw, 16'h0001, zw, 16'h0003, zw, 6'h19, 16'h5555, 16'h0001, zw, zw, 3'h0);
    op(zw, 16'hFFF9, 16'hFFFF, zw, 16'h0002, zw, 6'h1A, 16'hFFFD, 16'hFFFF, zw, zw, 3'h0);
    op(zw, 16'h0080, zw, zw, 16'h0001, zw, 6'h0A, 16'h0080, zw, zw, zw, 3'h1);
    op(zw, 16'hFF80, zw, zw, 16'h0001, zw, 6'h0A, 16'h0080, zw, zw, zw, 3'h0);
    repeat (2) @(posedge ref_clk);
    chk({24'h00_0000, n_div}, 32'h0000_0003);
    chk({24'h00_0000, n_stp}, 32'h0000_0001);
    conclude();
  end
endmodule
`default_nettype wire
